/* src/remote_pulse_rx.sv */
// Function
// R1: compare compare_data with first received byte
// R2: software enables compare and loads pattern first
// R3: width n compares bits n down to 0
// R4: match sets compare_match_flag
// R5: both units receive one signal; second classifies
// R6: software selects source and pin in second
// R7: count source selectable, divided by 1/8/32/64
// R8: 48-bit buffer wraps to first bit
// R9: software enables first then second unit
// R10: operating_flag follows within two source cycles
// R11: second unit operating flag reads meaningless zero
// R12: four settings place header and special detection
// R13: software uses only the four settings
// R14: data before header sets error, keeps rest
// R15: all flags and enables live in first
// R16: second-unit detections report through first unit
// R17: first unit requests interrupts; second never
// R18: each unit limits bound its assigned pattern
// R19: filter passes level after four equal samples
// R20: compare uses earliest bits on every update; code re-checks only on writes into byte 0 from bit n on
module remote_pulse_rx
  import rpc_pkg::*;
(
  input  wire logic        CORE_CLK,
  input  wire logic        RST_N,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic [3:0]  SRC_EN,
  input  wire logic        RC_PIN,
  output logic             IRQ
);
  // ---------------------------------------------------------------
  // Register state.
  // ---------------------------------------------------------------
  logic [2:0]  c0a_reg, c0a_next;    // First: run, header_enable, special_enable.
  logic [2:0]  c0b_reg, c0b_next;    // Second: run, sinv, input_filter_enable.
  logic [1:0]  c1_reg, c1_next;      // ext_header_select, ext_special_select.
  logic [3:0]  c2b_reg, c2b_next;    // Second: source select and divisor.
  logic [8:0]  st_reg, st_next;      // first_unit_status.
  logic [8:0]  ie_reg, ie_next;      // first_unit_irq_enable.
  logic [3:0]  cc_reg, cc_next;      // compare_control.
  logic [7:0]  cd_reg, cd_next;      // compare_data.
  logic [21:0] hl1_reg, hl1_next;    // First unit header_min/max_limit.
  logic [21:0] hl2_reg, hl2_next;    // Second unit header_min/max_limit.
  logic [31:0] dl_reg, dl_next;      // Data 0/1 min and max.
  logic [47:0] buf_reg, buf_next;    // Receive buffer.
  logic [5:0]  bc_reg, bc_next;      // received_bit_count.
  logic [15:0] per_reg, per_next;    // Pulse period in ticks.
  logic [1:0]  op_reg, op_next;      // Run-state delay pipe.
  rx_state_e   rx_reg, rx_next;      // Header tracking.
  logic [31:0] rd_reg, rd_next;      // Registered read data.
  // ---------------------------------------------------------------
  // Combinational helpers.
  // ---------------------------------------------------------------
  front_s      fr;                   // Tick, level and edge from the front end.
  src_cfg_s    cfg;                  // Second unit's source settings.
  logic        wr;                   // Write in access phase.
  logic        is_hdr;               // Period fits the header window.
  logic        is_sp;                // Period fits the special window.
  logic        is_d0;                // Period fits the data 0 window.
  logic        is_d1;                // Period fits the data 1 window.
  logic        pre_err;              // Pattern seen before a header.
  logic        cmp_hit;              // Compare match this cycle.
  logic        bit_wr;               // A data bit is stored this cycle.
  logic [21:0] hlim;                 // Limits used for the header.
  logic [21:0] slim;                 // Limits used for special data.
  logic        mapped;               // Address hits a register.
  logic [31:0] rmux;                 // Read mux.
  logic        oper;                 // operating_flag.

  // Inclusive window test, used for all four patterns.
  function automatic logic in_win(input logic [15:0] v, input logic [10:0] lo,
                                  input logic [10:0] hi);
    in_win = (v >= {5'd0, lo}) && (v <= {5'd0, hi});
  endfunction

  // Mask of bits n down to 0.
  function automatic logic [7:0] cmp_mask(input logic [2:0] n);
    cmp_mask = 8'hFF >> (3'd7 - n);
  endfunction

  // ---------------------------------------------------------------
  // Input front end: pin, source and filter all follow the second unit.
  // ---------------------------------------------------------------
  // The first unit's own source fields are not built, so it always counts
  // on the second unit's source through the second unit's divider.
  assign cfg = '{csrc: c2b_reg[1:0], cdiv: c2b_reg[3:2], sinv: c0b_reg[1],
                 input_filter_enable: c0b_reg[2]};  // R6

  pulse_front u_front (
    .CORE_CLK (CORE_CLK),
    .RST_N    (RST_N),
    .CFG      (cfg),
    .SRC_EN   (SRC_EN),
    .PIN      (RC_PIN),
    .FRONT    (fr)
  );

  assign oper = op_reg[1];
  assign wr   = PSEL & PENABLE & PWRITE;

  // ---------------------------------------------------------------
  // Read mux and address decode.
  // ---------------------------------------------------------------
  always_comb begin
    mapped = 1'b1;
    case (PADDR)
      OFS_CTRL0_FIRST:  rmux = {29'd0, c0a_reg};
      OFS_CTRL0_SECOND: rmux = {29'd0, c0b_reg};
      OFS_CTRL1_FIRST:  rmux = {30'd0, c1_reg};
      // Operating and input-level flags reported only by the first unit.
      OFS_CTRL2_FIRST:  rmux = {30'd0, fr.level, oper};  // R15
      // The second unit's operating flag always reads zero.
      OFS_CTRL2_SECOND: rmux = {28'd0, c2b_reg};  // R11
      OFS_STATUS:       rmux = {23'd0, st_reg};
      OFS_IRQ_ENABLE:   rmux = {23'd0, ie_reg};
      OFS_CMP_CTRL:     rmux = {28'd0, cc_reg};
      OFS_CMP_DATA:     rmux = {24'd0, cd_reg};
      OFS_HDR_LIM_1ST:  rmux = {5'd0, hl1_reg[21:11], 5'd0, hl1_reg[10:0]};
      OFS_HDR_LIM_2ND:  rmux = {5'd0, hl2_reg[21:11], 5'd0, hl2_reg[10:0]};
      OFS_DATA_LIM:     rmux = dl_reg;
      OFS_RX_LOW:       rmux = buf_reg[31:0];
      OFS_RX_HIGH:      rmux = {16'd0, buf_reg[47:32]};
      OFS_RX_BITS:      rmux = {26'd0, bc_reg};
      default: begin
        rmux   = REG_RESET;
        mapped = 1'b0;
      end
    endcase
  end

  // Zero wait states; the read word is captured in the setup phase.
  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL & PENABLE & ~mapped;
  assign PRDATA  = rd_reg;
  // Each unit's header limits serve whatever pattern it is assigned.
  assign hlim = c1_reg[0] ? hl2_reg : hl1_reg;  // R18 R12
  assign slim = c1_reg[1] ? hl2_reg : hl1_reg;  // R18 R12

  // ---------------------------------------------------------------
  // Pulse classification.
  // ---------------------------------------------------------------
  // Data windows are decoded once for the single combined signal.
  always_comb begin
    is_hdr  = fr.rise & oper & c0a_reg[1] & in_win(per_reg, hlim[10:0], hlim[21:11]);
    is_sp   = fr.rise & oper & c0a_reg[2] & in_win(per_reg, slim[10:0], slim[21:11]);
    is_d0   = fr.rise & oper & in_win(per_reg, {3'd0, dl_reg[7:0]},
                                       {3'd0, dl_reg[15:8]});  // R5
    is_d1   = fr.rise & oper & in_win(per_reg, {3'd0, dl_reg[23:16]},
                                       {3'd0, dl_reg[31:24]});  // R5
    pre_err = ~is_hdr & c0a_reg[1] & (rx_reg == RX_HUNT)
              & (is_d0 | is_d1 | is_sp);  // R14
    bit_wr  = ~is_hdr & ~is_sp & ~pre_err & (is_d0 | is_d1);
  end

  // ---------------------------------------------------------------
  // Next-state logic for all registers except the check helpers.
  // ---------------------------------------------------------------
  always_comb begin
    c0a_next = c0a_reg;
    c0b_next = c0b_reg;
    c1_next  = c1_reg;
    c2b_next = c2b_reg;
    st_next  = st_reg;
    ie_next  = ie_reg;
    cc_next  = cc_reg;
    cd_next  = cd_reg;
    hl1_next = hl1_reg;
    hl2_next = hl2_reg;
    dl_next  = dl_reg;
    buf_next = buf_reg;
    bc_next  = bc_reg;
    per_next = per_reg;
    op_next  = op_reg;
    rx_next  = rx_reg;
    cmp_hit  = 1'b0;
    rd_next  = (PSEL & ~PENABLE & ~PWRITE) ? rmux : rd_reg;
    // Software writes first; hardware events are merged after them.
    if (wr) begin
      case (PADDR)
        OFS_CTRL0_FIRST:  c0a_next = PWDATA[2:0];
        OFS_CTRL0_SECOND: c0b_next = PWDATA[2:0];
        OFS_CTRL1_FIRST:  c1_next  = PWDATA[1:0];
        OFS_CTRL2_SECOND: c2b_next = PWDATA[3:0];
        // Writing zero clears a flag; writing one leaves it.
        OFS_STATUS:       st_next  = st_reg & PWDATA[8:0];
        OFS_IRQ_ENABLE:   ie_next  = PWDATA[8:0];
        OFS_CMP_CTRL:     cc_next  = PWDATA[3:0];
        OFS_CMP_DATA:     cd_next  = PWDATA[7:0];
        OFS_HDR_LIM_1ST:  hl1_next = {PWDATA[26:16], PWDATA[10:0]};
        OFS_HDR_LIM_2ND:  hl2_next = {PWDATA[26:16], PWDATA[10:0]};
        OFS_DATA_LIM:     dl_next  = PWDATA;
        default: begin
        end
      endcase
    end
    // Run state moves on ticks only, so it settles within two of them.
    if (fr.tick) begin
      op_next = {op_reg[0], c0a_reg[0] & c0b_reg[0]};  // R10
    end
    // Period counter saturates so a long idle cannot wrap into a window.
    if (fr.rise) begin
      per_next = 16'd0;
    end else if (fr.tick && per_reg != 16'hFFFF) begin
      per_next = per_reg + 16'd1;
    end
    // An idle gap past the header maximum ends a frame.
    if (rx_reg == RX_DATA && per_reg > {5'd0, hlim[21:11]} && !fr.rise) begin
      rx_next          = RX_HUNT;
      st_next[ST_RCV]  = 1'b0;
      st_next[ST_DONE] = 1'b1;
    end
    // Detections from either unit land in the first unit's status.
    if (is_hdr) begin  // R16
      rx_next         = RX_DATA;
      st_next[ST_HDR] = 1'b1;
      st_next[ST_RCV] = 1'b1;
    end else if (pre_err) begin
      st_next[ST_ERR] = 1'b1;  // R14
    end else if (is_sp) begin
      st_next[ST_SPEC] = 1'b1;  // R16
    end else if (bit_wr) begin
      buf_next[bc_reg] = is_d1;
      st_next[ST_ZERO] = st_next[ST_ZERO] | is_d0;
      st_next[ST_ONE]  = st_next[ST_ONE] | is_d1;
      // The 49th bit overwrites bit 0 again.
      if (bc_reg == RX_BITS_MAX) begin  // R8
        bc_next          = 6'd0;
        st_next[ST_FULL] = 1'b1;
      end else begin
        bc_next = bc_reg + 6'd1;
      end
      // Earliest bits sit low in byte 0; re-check on every write there once
      // bit n is in, since a part-filled byte padded with zeros would match
      // a pattern that the line never carried.
      if (cc_reg[CMP_EN_BIT] && bc_reg < 6'd8
          && bc_reg >= {3'd0, cc_reg[2:0]}) begin  // R20 R1
        cmp_hit = ((buf_next[7:0] ^ cd_reg) & cmp_mask(cc_reg[2:0])) == 8'h00;  // R1 R3
      end
      st_next[ST_CMP] = st_next[ST_CMP] | cmp_hit;  // R4
    end
  end

  // ---------------------------------------------------------------
  // Register stage.
  // ---------------------------------------------------------------
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      c0a_reg <= REG_RESET[2:0];
      c0b_reg <= REG_RESET[2:0];
      c1_reg  <= REG_RESET[1:0];
      c2b_reg <= REG_RESET[3:0];
      st_reg  <= REG_RESET[8:0];
      ie_reg  <= REG_RESET[8:0];
      cc_reg  <= REG_RESET[3:0];
      cd_reg  <= REG_RESET[7:0];
      hl1_reg <= REG_RESET[21:0];
      hl2_reg <= REG_RESET[21:0];
      dl_reg  <= REG_RESET;
      buf_reg <= {REG_RESET[15:0], REG_RESET};
      bc_reg  <= REG_RESET[5:0];
      per_reg <= REG_RESET[15:0];
      op_reg  <= REG_RESET[1:0];
      rx_reg  <= RX_HUNT;
      rd_reg  <= REG_RESET;
    end else begin
      c0a_reg <= c0a_next;
      c0b_reg <= c0b_next;
      c1_reg  <= c1_next;
      c2b_reg <= c2b_next;
      st_reg  <= st_next;
      ie_reg  <= ie_next;
      cc_reg  <= cc_next;
      cd_reg  <= cd_next;
      hl1_reg <= hl1_next;
      hl2_reg <= hl2_next;
      dl_reg  <= dl_next;
      buf_reg <= buf_next;
      bc_reg  <= bc_next;
      per_reg <= per_next;
      op_reg  <= op_next;
      rx_reg  <= rx_next;
      rd_reg  <= rd_next;
    end
  end

  // Single request line from the first unit's status and enables.
  assign IRQ = |(st_reg & ie_reg);  // R17

  // ---------------------------------------------------------------
  // Check helpers: ticks seen while the run request holds still.
  // ---------------------------------------------------------------
  logic       run_q_reg, run_q_next;          // Run request one cycle ago.
  logic [1:0] run_ticks_reg, run_ticks_next;  // Steady ticks, saturating at three.

  // The count restarts whenever the request moves, so the flag is judged
  // only once two whole ticks have passed with a steady request.
  always_comb begin
    run_q_next     = c0a_reg[0] & c0b_reg[0];
    run_ticks_next = run_ticks_reg;
    if (run_q_next != run_q_reg) begin
      run_ticks_next = 2'd0;
    end else if (fr.tick && run_ticks_reg != 2'd3) begin
      run_ticks_next = run_ticks_reg + 2'd1;
    end
  end

  // Helper registers for the checks below.
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      run_q_reg     <= 1'b0;
      run_ticks_reg <= 2'd0;
    end else begin
      run_q_reg     <= run_q_next;
      run_ticks_reg <= run_ticks_next;
    end
  end

  // ---------------------------------------------------------------
  // Checks.
  // ---------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);

  a_cmp_flag_set: assert property (cmp_hit |=> st_reg[ST_CMP])  // R4
    else $error("compare match did not set its flag");
  a_cmp_masked: assert property (  // R3
    (bit_wr && cc_reg[CMP_EN_BIT] && bc_reg == 6'd0 && cc_reg[2:0] == 3'd0)
    |-> cmp_hit == (is_d1 == cd_reg[0]))
    else $error("one-bit compare result wrong");
  a_err_keeps: assert property (  // R14
    pre_err |=> st_reg[ST_ERR] && $stable(buf_reg) && $stable(st_reg[ST_SPEC:ST_ZERO]))
    else $error("pattern before header changed data state");
  a_buf_wrap: assert property (  // R8
    (bit_wr && bc_reg == RX_BITS_MAX) |=> bc_reg == 6'd0 && st_reg[ST_FULL])
    else $error("buffer did not wrap after 48 bits");
  a_oper_follow: assert property (run_ticks_reg >= 2'd2 |-> oper == run_q_reg)  // R10
    else $error("operating flag late after two ticks");
  a_oper_on_tick: assert property ($changed(oper) |-> $past(fr.tick))  // R10
    else $error("operating flag moved off a tick");
  a_hdr_second: assert property (  // R12
    (c1_reg == 2'b01 && fr.rise && oper && c0a_reg[1]
     && in_win(per_reg, hl2_reg[10:0], hl2_reg[21:11])) |-> is_hdr)
    else $error("header not taken from second unit limits");
  a_irq_gate: assert property ((st_reg & ie_reg) == 9'd0 |-> !IRQ)  // R17
    else $error("interrupt without enabled flag");
  a_status_w0c: assert property (  // R15
    (wr && PADDR == OFS_STATUS && !PWDATA[ST_ERR] && !pre_err) |=> !st_reg[ST_ERR])
    else $error("status write did not clear flag");

  c_header: cover property (is_hdr ##[1:1000] bit_wr);
  c_compare: cover property (cmp_hit);
  c_wrap: cover property (bit_wr && bc_reg == RX_BITS_MAX);
  c_error: cover property (pre_err);
endmodule

/* src/rpc_pkg.sv */
package rpc_pkg;
  // ---------------------------------------------------------------
  // Register offsets, byte addresses on the APB bus.
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL0_FIRST  = 8'h00;
  localparam logic [7:0] OFS_CTRL0_SECOND = 8'h04;
  localparam logic [7:0] OFS_CTRL1_FIRST  = 8'h08;
  localparam logic [7:0] OFS_CTRL2_FIRST  = 8'h0C;
  localparam logic [7:0] OFS_CTRL2_SECOND = 8'h10;
  localparam logic [7:0] OFS_STATUS       = 8'h14;
  localparam logic [7:0] OFS_IRQ_ENABLE   = 8'h18;
  localparam logic [7:0] OFS_CMP_CTRL     = 8'h1C;
  localparam logic [7:0] OFS_CMP_DATA     = 8'h20;
  localparam logic [7:0] OFS_HDR_LIM_1ST  = 8'h24;
  localparam logic [7:0] OFS_HDR_LIM_2ND  = 8'h28;
  localparam logic [7:0] OFS_DATA_LIM     = 8'h2C;
  localparam logic [7:0] OFS_RX_LOW       = 8'h30;
  localparam logic [7:0] OFS_RX_HIGH      = 8'h34;
  localparam logic [7:0] OFS_RX_BITS      = 8'h38;
  // ---------------------------------------------------------------
  // Status bit positions; the interrupt enable uses the same layout.
  // ---------------------------------------------------------------
  localparam int ST_CMP  = 0;
  localparam int ST_ERR  = 1;
  localparam int ST_RCV  = 2;
  localparam int ST_FULL = 3;
  localparam int ST_HDR  = 4;
  localparam int ST_ZERO = 5;
  localparam int ST_ONE  = 6;
  localparam int ST_SPEC = 7;
  localparam int ST_DONE = 8;
  localparam int CMP_EN_BIT = 3;  // Compare enable inside compare_control.
  // ---------------------------------------------------------------
  // Sizes, reset values and counts.
  // ---------------------------------------------------------------
  localparam logic [5:0]  RX_BITS_MAX  = 6'd47;   // Last buffer bit index.
  localparam logic [31:0] REG_RESET    = 32'h0000_0000;
  localparam int          FILTER_LEN   = 4;       // Equal samples to pass.
  localparam int          OPER_DELAY   = 2;       // Count-source cycles.
  localparam logic [5:0]  DIV1_LIMIT   = 6'd0;
  localparam logic [5:0]  DIV8_LIMIT   = 6'd7;
  localparam logic [5:0]  DIV32_LIMIT  = 6'd31;
  localparam logic [5:0]  DIV64_LIMIT  = 6'd63;
  // ---------------------------------------------------------------
  // Types.
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [1:0] csrc;  // 0 subsystem, 1 main peripheral, 2/3 timer underflows.
    logic [1:0] cdiv;  // 0 /1, 1 /8, 2 /32, 3 /64.
    logic       sinv;  // Invert the input pin.
    logic       input_filter_enable;   // Four-sample input filter.
  } src_cfg_s;
  typedef struct packed {
    logic tick;        // One count-source cycle.
    logic level;       // Filtered internal level.
    logic rise;        // Rising edge of the internal level, on a tick.
  } front_s;
  typedef enum logic [1:0] {
    RX_HUNT = 2'b00,   // Waiting for a header.
    RX_DATA = 2'b01    // Header seen, data bits accepted.
  } rx_state_e;
endpackage

/* src/pulse_front.sv */
module pulse_front
  import rpc_pkg::*;
(
  input  wire logic     CORE_CLK,
  input  wire logic     RST_N,
  input  wire src_cfg_s CFG,
  input  wire logic [3:0] SRC_EN,
  input  wire logic     PIN,
  output front_s        FRONT
);
  // ---------------------------------------------------------------
  // Count source: selected enable, then the divider.
  // ---------------------------------------------------------------
  logic [5:0] div_reg, div_next;     // Divider count.
  logic [3:0] smp_reg, smp_next;     // Last four input samples.
  logic       lvl_reg, lvl_next;     // Filtered level.
  logic       tick_reg, tick_next;   // Registered tick.
  logic       rise_reg, rise_next;   // Registered rising edge.
  logic [5:0] limit;                 // Divider wrap value.
  logic       src_pulse;             // Undivided source enable.

  // The divider limit is a table lookup so that no multiply is built.
  function automatic logic [5:0] div_limit(input logic [1:0] code);
    case (code)
      2'd1:    div_limit = DIV8_LIMIT;
      2'd2:    div_limit = DIV32_LIMIT;
      2'd3:    div_limit = DIV64_LIMIT;
      default: div_limit = DIV1_LIMIT;
    endcase
  endfunction

  // Next state of divider, sampler and filter.
  always_comb begin
    limit     = div_limit(CFG.cdiv);
    src_pulse = SRC_EN[CFG.csrc];
    div_next  = div_reg;
    smp_next  = smp_reg;
    lvl_next  = lvl_reg;
    tick_next = 1'b0;
    rise_next = 1'b0;
    if (src_pulse) begin  // R7
      if (div_reg >= limit) begin
        div_next  = 6'd0;
        tick_next = 1'b1;
      end else begin
        div_next = div_reg + 6'd1;
      end
    end
    if (tick_next) begin
      smp_next = {smp_reg[2:0], PIN ^ CFG.sinv};
      // A glitch shorter than four ticks never reaches the decoder.
      if (!CFG.input_filter_enable) begin
        lvl_next = smp_next[0];
      end else if (smp_next == {FILTER_LEN{smp_next[0]}}) begin  // R19
        lvl_next = smp_next[0];
      end
      rise_next = lvl_next & ~lvl_reg;
    end
  end

  // Register stage.
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      div_reg  <= 6'd0;
      smp_reg  <= 4'd0;
      lvl_reg  <= 1'b0;
      tick_reg <= 1'b0;
      rise_reg <= 1'b0;
    end else begin
      div_reg  <= div_next;
      smp_reg  <= smp_next;
      lvl_reg  <= lvl_next;
      tick_reg <= tick_next;
      rise_reg <= rise_next;
    end
  end

  assign FRONT = '{tick: tick_reg, level: lvl_reg, rise: rise_reg};

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  a_filter_hold: assert property (  // R19
    ($past(CFG.input_filter_enable) && $changed(lvl_reg)) |-> $past(smp_next) == {4{lvl_reg}})
    else $error("filtered level changed without four equal samples");
endmodule

/* testbench/rc_source.sv */
// -------------------------------------------------------------
// Remote-control pulse source standing at the far side of RC_PIN.
// -------------------------------------------------------------
module rc_source (
  input  wire logic clk,
  output logic      pin
);
  timeunit 1ns;
  timeprecision 1ps;

  // The line idles low between frames, as a pulled-down line would.
  initial pin = 1'b0;

  // Core cycles per count-source tick; the bench sets it for each pass.
  int scale = 1;

  // One pulse: four ticks high, then low until the next rising edge.
  task automatic pulse(input int period);
    @(posedge clk) pin <= 1'b1;
    repeat (4 * scale) @(posedge clk);
    pin <= 1'b0;
    repeat (period * scale - 4 * scale - 1) @(posedge clk);
  endtask

  // A quiet gap of so many ticks with the line held low.
  task automatic idle(input int cycles);
    repeat (cycles * scale) @(posedge clk);
  endtask
endmodule

/* testbench/testbench.sv */
module testbench
  import rpc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // -------------------------------------------------------------
  // Signals and counters.
  // -------------------------------------------------------------
  logic        core_clk, rst_n, psel, penable, pwrite, pready, pslverr, irq, rc_pin;
  logic [7:0]  paddr;
  logic [3:0]  src_en;
  logic [31:0] pwdata, prdata, rd;
  logic        err;
  int          fail_count, samples_checked;
  // Status bits that the frame checks look at.
  localparam logic [31:0] ST_MASK = (32'h1 << ST_CMP) | (32'h1 << ST_ERR) |
    (32'h1 << ST_HDR) | (32'h1 << ST_ZERO) | (32'h1 << ST_ONE) | (32'h1 << ST_FULL);

  remote_pulse_rx dut (.CORE_CLK(core_clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .SRC_EN(src_en), .RC_PIN(rc_pin), .IRQ(irq));
  rc_source src (.clk(core_clk), .pin(rc_pin));

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // -------------------------------------------------------------
  // Shared tasks.
  // -------------------------------------------------------------
  task automatic summarize();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Compares one 32-bit result; an unknown bit matches only an unknown expected bit.
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One APB transfer; the wait for PREADY is bounded so a hang ends the run.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      fail_count++;
      summarize();
    end
    @(posedge core_clk);
  endtask

  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
  endtask

  // Expected compare result: bits n down to 0 of byte and pattern agree.
  function automatic logic exp_cmp(input logic [7:0] rx, input logic [7:0] cd,
                                   input logic [2:0] n);
    return ((rx ^ cd) & (8'hFF >> (3'h7 - n))) == 8'h00;
  endfunction

  // Core cycles per count-source tick for each divisor code.
  function automatic int exp_scale(input logic [1:0] code);
    return (code == 2'd0) ? 1 : (code == 2'd1) ? 8 : (code == 2'd2) ? 32 : 64;
  endfunction
  // -------------------------------------------------------------
  // Main sequence: every pass starts from a fresh reset.
  // -------------------------------------------------------------
  initial begin
    logic [7:0]  bits, cd;
    logic [2:0]  n;
    logic        m;
    logic [31:0] st;
    logic [1:0]  cs, dv;
    logic        fl;
    int          s;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    rst_n = 1'b0;
    fail_count = 0;
    samples_checked = 0;
    void'($urandom(28));
    for (int it = 0; it < 4; it++) begin
      // Each pass takes a random source and the next divisor, so all four
      // divisors run; the model's pulse lengths follow the tick time.
      cs = 2'($urandom);
      dv = it[1:0];
      s = exp_scale(dv);
      fl = (it == 1) ? 1'b1 : 1'($urandom);
      src.scale = s;
      src_en <= 4'h1 << cs;
      do_reset();
      bits = 8'($urandom);
      n = (it == 0) ? 3'h7 : (it == 1) ? 3'h0 : 3'($urandom);
      cd = ($urandom & 1) ? bits : 8'($urandom);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk("status after reset", REG_RESET, rd);
      apb(1'b0, 8'h3C, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, err});
      chk("unmapped data", 32'h0, rd);
      // Header in the second unit on its chosen source; pattern loaded first.
      apb(1'b1, OFS_CTRL2_SECOND, {28'h0, dv, cs});
      apb(1'b1, OFS_CTRL1_FIRST, 32'h1);
      apb(1'b1, OFS_HDR_LIM_2ND, {5'h0, 11'h2D, 5'h0, 11'h23});
      apb(1'b1, OFS_DATA_LIM, {8'h16, 8'h12, 8'h0C, 8'h08});
      apb(1'b1, OFS_CMP_CTRL, {28'h0, 1'b1, n});
      apb(1'b1, OFS_CMP_DATA, {24'h0, cd});
      apb(1'b1, OFS_IRQ_ENABLE, 32'h1 << ST_CMP);
      apb(1'b1, OFS_CTRL0_FIRST, 32'h3);
      apb(1'b1, OFS_CTRL0_SECOND, {29'h0, fl, 2'b01});
      repeat (2 * s) @(posedge core_clk);
      apb(1'b0, OFS_CTRL2_FIRST, 32'h0);
      chk("operating on", 32'h1, rd & 32'h3);
      src.idle(60);
      if (it == 0) begin
        // Data pulses with no header must only raise the error flag.
        repeat (3) src.pulse(10);
        src.pulse(8);
        src.idle(60);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk("pre-header status", 32'h1 << ST_ERR, rd & ST_MASK);
        apb(1'b0, OFS_RX_LOW, 32'h0);
        chk("pre-header data", 32'h0, rd);
        apb(1'b1, OFS_STATUS, 32'h0);
      end
      src.pulse(40);
      // The first pass sends 56 bits, so the buffer wraps once and ends on bits.
      for (int b = 0; b < ((it == 0) ? 56 : 8); b++) src.pulse(bits[b % 8] ? 20 : 10);
      src.pulse(8);
      src.idle(20);
      m = exp_cmp(bits, cd, n);
      chk("irq", {31'h0, m}, {31'h0, irq});
      apb(1'b0, OFS_RX_LOW, 32'h0);
      chk("first byte", {24'h0, bits}, rd & 32'hFF);
      apb(1'b0, OFS_RX_HIGH, 32'h0);
      chk("buffer high", (it == 0) ? {16'h0, bits, bits} : 32'h0, rd);
      apb(1'b0, OFS_RX_BITS, 32'h0);
      chk("bit count", 32'h8, rd);
      st = 32'h0;
      st[ST_CMP] = m;
      st[ST_HDR] = 1'b1;
      st[ST_ZERO] = (bits != 8'hFF);
      st[ST_ONE] = (bits != 8'h00);
      st[ST_FULL] = (it == 0);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk("status", st, rd & ST_MASK);
      // A gap past the header maximum closes the frame.
      src.idle(30);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk("frame end", 32'h2, {30'h0, rd[ST_DONE], rd[ST_RCV]});
      apb(1'b1, OFS_CTRL0_FIRST, 32'h0);
      apb(1'b1, OFS_CTRL0_SECOND, 32'h0);
      repeat (2 * s) @(posedge core_clk);
      apb(1'b0, OFS_CTRL2_FIRST, 32'h0);
      chk("operating off", 32'h0, rd & 32'h3);
    end
    summarize();
  end
endmodule
